// ==== rtl/crat_pkg.sv ====
package crat_pkg;
   // virtual address layout
   localparam int CRAT_VA_W = 16;
   localparam int CRAT_EA_W = 32;
   localparam int CRAT_PART_REGS = 128;
   localparam int CRAT_HW_REGS = 32;
   localparam int CRAT_R0_REGS = 32;
   localparam int CRAT_R4_REGS = 64;
   localparam int CRAT_HW_OFF_W = 5;
   localparam int CRAT_R4_OFF_W = 6;
   localparam logic [15:0] CRAT_HW_BASE = 16'h0000;
   localparam logic [15:0] CRAT_R0_BASE = 16'h4000;
   localparam logic [15:0] CRAT_R4_BASE = 16'h8000;
   localparam logic [15:0] CRAT_WIN_END = 16'h3fff;
   localparam logic [15:0] CRAT_WIN_BASE_LG = 16'h3000;
   localparam logic [15:0] CRAT_WIN_BASE_SM = 16'h3c00;
   // physical file
   localparam int CRAT_PA_W_LG = 12;
   localparam int CRAT_PA_W_SM = 10;
   localparam int CRAT_IDX_W_LG = 5;
   localparam int CRAT_IDX_W_SM = 3;
   localparam int CRAT_DATA_W = 64;
   // region tags in the physical address
   localparam logic [1:0] CRAT_TAG_HW = 2'h0;
   localparam logic [1:0] CRAT_TAG_R0 = 2'h1;
   localparam logic CRAT_TAG_R4 = 1'h1;
   // ring numbers
   localparam logic [2:0] CRAT_RING0 = 3'h0;
   typedef enum logic [2:0] {
      CRAT_REG_NONE,
      CRAT_REG_HW,
      CRAT_REG_R0,
      CRAT_REG_R4,
      CRAT_REG_WIN
   } crat_region_t;
endpackage

// ==== rtl/crat_translate.sv ====
`timescale 1ns/1ps
// Overview of operation
// - same index value gives same physical partition
// - partitions are consecutive 128-register blocks
// - 16-bit virtual address selects one 64-bit register
// - only low 16 effective-address bits used
// - each register carries a lock bit
// - regions: 32 hardware, 32 ring0, 64 ring4
// - rings 1-4 reach only the ring4 region
// - region bases 0000, 4000, 8000
// - explicit addresses range checked, exception raised
// - low-privilege access to privileged region traps
// - undefined ranges trap except physical window
// - window 3000-3fff large, 3c00-3fff small
// - ring0 window reaches any partition
// - every register has two addresses, window ends 3fff
// - small variant: 1024 registers, 128-register partitions
// - partition index register is 5 bits, 3 in the small variant
// - physical address is index plus region bits
// - window base is 3000 (3c00 small) plus index times 80
module crat_translate
   import crat_pkg::*;
#(
   parameter bit SMALL = 1'b0,
   parameter int IDX_W = SMALL ? CRAT_IDX_W_SM : CRAT_IDX_W_LG,
   parameter int PA_W = SMALL ? CRAT_PA_W_SM : CRAT_PA_W_LG,
   parameter int DATA_W = CRAT_DATA_W
) (
   // clock and reset
   input wire logic sys_clk_in,
   input wire logic rst_in,
   // index register load
   input wire logic idx_wr_in,
   input wire logic [IDX_W-1:0] idx_wdata_in,
   output logic [IDX_W-1:0] idx_out,
   // access request from the instruction pipeline
   input wire logic req_in,
   input wire logic [CRAT_EA_W-1:0] eff_addr_in,
   input wire logic [2:0] ring_in,
   input wire logic wr_in,
   input wire logic [DATA_W-1:0] wdata_in,
   input wire logic lock_wr_in,
   input wire logic lock_wdata_in,
   // answer
   output logic ack_out,
   output logic trap_out,
   output logic [PA_W-1:0] paddr_out,
   output logic [DATA_W-1:0] rdata_out,
   output logic lock_out
);

   localparam int DEPTH = 1 << PA_W;
   localparam int WIN_OFF_W = PA_W;
   localparam logic [15:0] WIN_BASE = SMALL ? CRAT_WIN_BASE_SM :
                                             CRAT_WIN_BASE_LG;

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   function automatic crat_region_t decode(input logic [15:0] va);
      crat_region_t r;
      r = CRAT_REG_NONE;
      if (va >= CRAT_HW_BASE && va < CRAT_HW_BASE + 16'(CRAT_HW_REGS))
         r = CRAT_REG_HW;
      else if (va >= WIN_BASE && va <= CRAT_WIN_END)
         r = CRAT_REG_WIN;
      else if (va >= CRAT_R0_BASE &&
               va < CRAT_R0_BASE + 16'(CRAT_R0_REGS))
         r = CRAT_REG_R0;
      else if (va >= CRAT_R4_BASE &&
               va < CRAT_R4_BASE + 16'(CRAT_R4_REGS))
         r = CRAT_REG_R4;
      return r;
   endfunction

   // ---------------------------------------------------------------
   // partition index register
   // ---------------------------------------------------------------
   logic [IDX_W-1:0] idx_r;
   logic [IDX_W-1:0] idx_nxt;

   always_comb begin
      idx_nxt = idx_r;
      if (idx_wr_in) begin
         idx_nxt = idx_wdata_in;
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         idx_r <= '0;
      end else begin
         idx_r <= idx_nxt;
      end
   end

   assign idx_out = idx_r;

   // ---------------------------------------------------------------
   // translation and protection
   // ---------------------------------------------------------------
   logic [15:0] va;
   crat_region_t region;
   logic priv;
   logic bad;
   logic [PA_W-1:0] pa;

   // upper half of the effective address is ignored on purpose
   assign va = eff_addr_in[CRAT_VA_W-1:0];
   assign region = decode(va);
   assign priv = (ring_in == CRAT_RING0);

   always_comb begin
      pa = '0;
      bad = 1'b0;
      unique case (region)
         CRAT_REG_HW: begin
            // index selects the partition, so shared index = shared data
            pa = {idx_r, CRAT_TAG_HW, va[CRAT_HW_OFF_W-1:0]};
            bad = !priv;
         end
         CRAT_REG_R0: begin
            pa = {idx_r, CRAT_TAG_R0, va[CRAT_HW_OFF_W-1:0]};
            bad = !priv;
         end
         CRAT_REG_R4: begin
            pa = {idx_r, CRAT_TAG_R4, va[CRAT_R4_OFF_W-1:0]};
         end
         CRAT_REG_WIN: begin
            // fixed map, independent of the index register
            pa = va[WIN_OFF_W-1:0];
            bad = !priv;
         end
         CRAT_REG_NONE: begin
            bad = 1'b1;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // register file with lock bits
   // ---------------------------------------------------------------
   // partitions are contiguous because the index forms the top bits
   logic [DATA_W-1:0] mem [DEPTH];
   logic lock_mem [DEPTH];

   logic go;
   assign go = req_in && !bad;

   // storage has no reset: contents are software state
   always_ff @(posedge sys_clk_in) begin
      if (go && wr_in) begin
         mem[pa] <= wdata_in;
      end
      if (go && lock_wr_in) begin
         lock_mem[pa] <= lock_wdata_in;
      end
   end

   // ---------------------------------------------------------------
   // answer registers
   // ---------------------------------------------------------------
   logic ack_r, ack_nxt;
   logic trap_r, trap_nxt;
   logic [PA_W-1:0] pa_r, pa_nxt;
   logic [DATA_W-1:0] rd_r, rd_nxt;
   logic lock_r, lock_nxt;

   always_comb begin
      ack_nxt = req_in;
      trap_nxt = req_in && bad;
      pa_nxt = pa_r;
      rd_nxt = rd_r;
      lock_nxt = lock_r;
      if (go) begin
         pa_nxt = pa;
         rd_nxt = mem[pa];
         lock_nxt = lock_mem[pa];
      end
   end

   always_ff @(posedge sys_clk_in or posedge rst_in) begin
      if (rst_in) begin
         ack_r <= 1'b0;
         trap_r <= 1'b0;
         pa_r <= '0;
         rd_r <= '0;
         lock_r <= 1'b0;
      end else begin
         ack_r <= ack_nxt;
         trap_r <= trap_nxt;
         pa_r <= pa_nxt;
         rd_r <= rd_nxt;
         lock_r <= lock_nxt;
      end
   end

   assign ack_out = ack_r;
   assign trap_out = trap_r;
   assign paddr_out = pa_r;
   assign rdata_out = rd_r;
   assign lock_out = lock_r;

endmodule

// ==== tb/crat_cpu_model.sv ====
`timescale 1ns/1ps
module crat_cpu_model (
   input wire logic sys_clk_in,
   output logic req_out,
   output logic [31:0] addr_out,
   output logic [2:0] ring_out,
   output logic wr_out,
   output logic [63:0] wdata_out,
   output logic lock_wr_out,
   output logic lock_out
);
   initial begin
      {req_out, wr_out, lock_wr_out, lock_out, ring_out} = '0;
      addr_out = '0;
      wdata_out = '0;
   end
   // one request per call; released addr, data and lock lines show the inverse, ring keeps its value
   task automatic acc(input logic [31:0] a, input logic [2:0] r,
      input logic w, input logic [63:0] d, input logic lw, input logic l);
      @(negedge sys_clk_in);
      {req_out, wr_out, lock_wr_out, lock_out, ring_out} = {1'h1, w, lw, l, r};
      addr_out = a;
      wdata_out = d;
      @(negedge sys_clk_in);
      {req_out, wr_out, lock_wr_out} = '0;
      lock_out = ~l;
      addr_out = ~a;
      wdata_out = ~d;
   endtask
endmodule

// ==== tb/crat_translate_assertions.sv ====
`timescale 1ns/1ps
module crat_translate_chk
   import crat_pkg::*;
#(
   parameter bit SMALL = 1'b0,
   parameter int IDX_W = 5,
   parameter int PA_W = 12
) (
   input wire logic sys_clk_in,
   input wire logic rst_in,
   input wire logic req_in,
   input wire logic [CRAT_EA_W-1:0] eff_addr_in,
   input wire logic [2:0] ring_in,
   input wire logic [IDX_W-1:0] idx_out,
   input wire logic ack_out,
   input wire logic trap_out,
   input wire logic [PA_W-1:0] paddr_out
);
   wire logic [15:0] a = eff_addr_in[15:0];
   wire logic usr = ring_in != CRAT_RING0;
   // the window is smaller in the small variant, the rest is undefined
   wire logic win = SMALL ? (a[15:10] == 6'h0f) : (a[15:12] == 4'h3);
   wire logic undef_sm = SMALL && (a >= 16'h3000) && (a <= 16'h3bff);
   default clocking @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);
   chk_ack_each: assert property (req_in |=> ack_out)
      else $error("missing ack");
   chk_ack_only: assert property (!req_in |=> !ack_out && !trap_out)
      else $error("stray ack");
   chk_user_priv: assert property (
      req_in && usr && !a[15] |=> trap_out)
      else $error("user reached privileged");
   chk_undef_trap: assert property (
      req_in && (undef_sm || a inside {[16'h0020:16'h2fff],
      [16'h4020:16'h7fff], [16'h8040:16'hffff]}) |=> trap_out)
      else $error("undefined address passed");
   chk_win_map: assert property (req_in && !usr && win
      |=> !trap_out && paddr_out == $past(a[PA_W-1:0]))
      else $error("window map");
   chk_hw_map: assert property (req_in && !usr && a[15:5] == 11'h0
      |=> paddr_out == {$past(idx_out), 2'b00, $past(a[4:0])})
      else $error("hardware map");
   chk_r4_map: assert property (req_in && a[15:6] == 10'h200
      |=> !trap_out && paddr_out == {$past(idx_out), 1'b1, $past(a[5:0])})
      else $error("ring4 map");
   chk_trap_keep: assert property (trap_out |-> $stable(paddr_out))
      else $error("trap changed address");
endmodule

// ==== tb/crat_translate_tb.sv ====
`timescale 1ns/1ps
`define CHK(x, y) begin cmp_count++; if ((x) !== (y)) begin n_fail++; \
   $display("Error %0t mismatch %h %h", $time, x, y); end end
module crat_translate_tb;
   import crat_pkg::*;
   logic sys_clk_in = 1'b0, rst_in = 1'b1, idx_wr_in = 1'b0;
   logic req_in, wr_in, lock_wr_in, lock_wdata_in, ack_out, trap_out;
   logic lock_out;
   logic [4:0] idx_wdata_in = '0, idx_out;
   logic [31:0] eff_addr_in;
   logic [2:0] ring_in;
   logic [63:0] wdata_in, rdata_out;
   logic [11:0] paddr_out;
   logic [2:0] sm_idx_out;
   logic sm_ack, sm_trap, sm_lock;
   logic [9:0] sm_paddr;
   logic [63:0] sm_rdata;
   logic [19:0] tv [10];
   int n_fail = 0, cmp_count = 0, cyc = 0;
   always #12.5 sys_clk_in = ~sys_clk_in;
   always @(posedge sys_clk_in) begin
      cyc++;
      if (cyc == 2000) begin
         n_fail++;
         test_done();
      end
   end
   crat_translate u_crat_translate (.*);
   // small variant shares the stimulus, only the low index bits reach it
   crat_translate #(.SMALL(1'b1)) u_crat_translate_small (
      .sys_clk_in, .rst_in, .idx_wr_in, .idx_wdata_in(idx_wdata_in[2:0]),
      .idx_out(sm_idx_out), .req_in, .eff_addr_in, .ring_in, .wr_in,
      .wdata_in, .lock_wr_in, .lock_wdata_in, .ack_out(sm_ack),
      .trap_out(sm_trap), .paddr_out(sm_paddr), .rdata_out(sm_rdata),
      .lock_out(sm_lock));
   crat_cpu_model u_crat_cpu_model (.sys_clk_in, .req_out(req_in),
      .addr_out(eff_addr_in), .ring_out(ring_in), .wr_out(wr_in),
      .wdata_out(wdata_in), .lock_wr_out(lock_wr_in),
      .lock_out(lock_wdata_in));
   // ----------------------------------------
   // tasks
   // ----------------------------------------
   task automatic go(input logic [31:0] a, input logic [2:0] r,
      input logic w, input logic [63:0] d, input logic l, input logic t);
      u_crat_cpu_model.acc(a, r, w, d, l, l);
      `CHK(ack_out, 1'b1)
      `CHK(trap_out, t)
   endtask
   task automatic load(input logic [4:0] i);
      @(negedge sys_clk_in);
      idx_wr_in = 1'b1;
      idx_wdata_in = i;
      @(negedge sys_clk_in);
      idx_wr_in = 1'b0;
      `CHK(idx_out, i)
   endtask
   task automatic t_map;
      load(5'h1f);
      go(32'hffff_8005, 3'h4, 1'b1, 64'h1234_5678_9abc_def0, 1'b1, 1'b0);
      `CHK(paddr_out, 12'hfc5)
      load(5'h00);
      go(32'h0000_3fc5, 3'h0, 1'b0, '0, 1'b0, 1'b0);
      `CHK(paddr_out, 12'hfc5)
      `CHK(rdata_out, 64'h1234_5678_9abc_def0)
      `CHK(lock_out, 1'b1)
      go(32'h0000_401f, 3'h0, 1'b0, '0, 1'b0, 1'b0);
      `CHK(paddr_out, 12'h03f)
      $display("map test done");
   endtask
   task automatic t_trap;
      tv = '{{16'h0000, 4'h9}, {16'h4000, 4'h9}, {16'h3000, 4'h3},
         {16'h0020, 4'h1}, {16'h4020, 4'h1}, {16'h8040, 4'h1},
         {16'h2fff, 4'h1}, {16'h3000, 4'h0}, {16'h803f, 4'h8},
         {16'h8000, 4'h2}};
      foreach (tv[i])
         go({16'h0, tv[i][19:4]}, tv[i][3:1], 1'b0, '0, 1'b0,
            tv[i][0]);
      $display("trap test done");
   endtask
   task automatic t_small;
      load(5'h03);
      `CHK(sm_idx_out, 3'h3)
      go(32'h0000_8001, 3'h4, 1'b1, 64'h0bad_cafe_0123_4567, 1'b1, 1'b0);
      `CHK(sm_paddr, 10'h1c1)
      go(32'h0000_3dc1, 3'h0, 1'b0, '0, 1'b0, 1'b0);
      `CHK(sm_trap, 1'b0)
      `CHK(sm_paddr, 10'h1c1)
      `CHK(sm_rdata, 64'h0bad_cafe_0123_4567)
      `CHK(sm_lock, 1'b1)
      go(32'h0000_3bff, 3'h0, 1'b0, '0, 1'b0, 1'b0);
      `CHK(sm_ack, 1'b1)
      `CHK(sm_trap, 1'b1)
      $display("small test done");
   endtask
   task automatic test_done;
      $display("compares %0d fails %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   initial begin
      repeat (8) @(posedge sys_clk_in);
      @(negedge sys_clk_in);
      rst_in = 1'b0;
      t_map();
      t_trap();
      t_small();
      test_done();
   end
endmodule
bind crat_translate crat_translate_chk #(.SMALL(SMALL), .IDX_W(IDX_W),
   .PA_W(PA_W)) u_chk (.*);
